// File: src/tlp_pkg.sv
// Purpose: constants and types for the two-level priority interrupt block
// Assumes: one 200 MHz clock, AHB-Lite word access
// Notes:   offsets are byte addresses of aligned 32-bit words
package tlp_pkg;

    // ========================================================
    // register offsets
    localparam logic [7:0] OFS_MAIN_CTL   = 8'h00;
    localparam logic [7:0] OFS_EDGE_CTL   = 8'h04;
    localparam logic [7:0] OFS_PIN_CTL    = 8'h08;
    localparam logic [7:0] OFS_RESET_CTL  = 8'h0C;
    localparam logic [7:0] OFS_PIN_CHG_EN = 8'h10;
    localparam logic [7:0] OFS_SERVICE    = 8'h14;

    // ========================================================
    // reset values and writable masks
    localparam logic [7:0] RST_MAIN_CTL   = 8'h00;
    localparam logic [7:0] RST_EDGE_CTL   = 8'hF5;
    localparam logic [7:0] RST_PIN_CTL    = 8'hC0;
    localparam logic [7:0] RST_PIN_CHG_EN = 8'h00;
    localparam logic [7:0] MSK_EDGE_CTL   = 8'hF5;
    localparam logic [7:0] MSK_PIN_CTL    = 8'hDB;

    // ========================================================
    // field positions, main control
    localparam int GLOBAL_HIGH_EN_BIT  = 7;
    localparam int PERIPH_LOW_EN_BIT   = 6;
    localparam int TMR0_EN_BIT         = 5;
    localparam int EXT0_EN_BIT         = 4;
    localparam int PCHG_EN_BIT         = 3;
    localparam int TMR0_FLAG_BIT       = 2;
    localparam int EXT0_FLAG_BIT       = 1;
    localparam int PCHG_FLAG_BIT       = 0;
    // edge / priority control
    localparam int EXT0_EDGE_BIT       = 6;
    localparam int EXT1_EDGE_BIT       = 5;
    localparam int EXT2_EDGE_BIT       = 4;
    localparam int TMR0_PRIO_BIT       = 2;
    localparam int PCHG_PRIO_BIT       = 0;
    // external pin control
    localparam int EXT2_PRIO_BIT       = 7;
    localparam int EXT1_PRIO_BIT       = 6;
    localparam int EXT2_EN_BIT         = 4;
    localparam int EXT1_EN_BIT         = 3;
    localparam int EXT2_FLAG_BIT       = 1;
    localparam int EXT1_FLAG_BIT       = 0;
    // reset control
    localparam int PRIO_LEVEL_EN_BIT   = 7;

    // ========================================================
    // vectors and widths
    localparam logic [15:0] VEC_HIGH   = 16'h0008;
    localparam logic [15:0] VEC_LOW    = 16'h0018;
    localparam int PORT_W              = 8;
    localparam int PERIPH_W            = 8;
    localparam int EXT_W               = 3;

    // ========================================================
    // carriers
    typedef struct packed {
        logic        instr_end;  // instruction boundary pulse
        logic        return_from_isr_instr;     // return-from-isr executes now
        logic [15:0] ret_addr;   // address to resume at
    } tlp_core_in_t;

    typedef struct packed {
        logic        vec_valid;  // one-cycle vector load
        logic [15:0] vec_addr;
        logic        push;       // push ret address
        logic [15:0] push_addr;
    } tlp_core_out_t;

    typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT} tlp_bus_state_t;

    typedef struct packed {
        logic [7:0]     main_ctl;
        logic [7:0]     edge_ctl;
        logic [7:0]     pin_ctl;
        logic           prio_en;
        logic [7:0]     pin_chg_en;
        logic [7:0]     port_last;
        logic           in_high;
        logic           in_low;
        tlp_bus_state_t bus;
        logic           bus_wr;
        logic [7:0]     bus_addr;
        logic           hreadyout;
        logic [31:0]    hrdata;
        logic           hresp;
        tlp_core_out_t  core;
    } tlp_state_t;

endpackage

// File: src/tlp_pin_sync.sv
// Purpose: two-flop synchroniser with edge pulses for pin inputs
// Assumes: pins are asynchronous to hclk
// Notes:   edges are seen between the second and third stage only
`timescale 1ns/1ps
module tlp_pin_sync #(
    parameter int W = 11
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } tlp_sync_t;

    tlp_sync_t s;
    tlp_sync_t next_s;

    // ========================================================
    // shift chain; s1 is read by s2 only
    always_comb
    begin
        next_s    = s;
        next_s.s1 = pin;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    // edge taps behind the second stage
    assign level = s.s2;
    assign rise  = s.s2 & ~s.s3;
    assign fall  = ~s.s2 & s.s3;

endmodule // tlp_pin_sync

// File: src/tlp_intc.sv
// Purpose: two-level priority interrupt controller with AHB-Lite registers
// Assumes: core gives instruction boundaries and return-from-isr pulses
// Notes:   peripheral inputs arrive already flagged and enabled
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

module tlp_intc (
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        ce,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    input  wire logic                        timer_zero_overflow,
    input  wire logic [2:0]                  ext_irq_pin,
    input  wire logic [tlp_pkg::PORT_W-1:0]  port_pin,
    input  wire logic [tlp_pkg::PERIPH_W-1:0] periph_req,
    input  wire logic [tlp_pkg::PERIPH_W-1:0] periph_prio,
    input  wire tlp_pkg::tlp_core_in_t       core_in,
    output tlp_pkg::tlp_core_out_t           core_out
);

    tlp_pkg::tlp_state_t s;
    tlp_pkg::tlp_state_t next_s;

    logic [10:0] pin_level;
    logic [10:0] pin_rise;
    logic [10:0] pin_fall;
    logic [2:0]  ext_evt;
    logic        pchg_evt;
    logic [4:0]  core_pend;
    logic [4:0]  core_prio;
    logic        high_any;
    logic        low_any;
    logic        take_high;
    logic        take_low;
    logic        take_any;
    logic        bus_start;
    logic        do_write;
    logic [7:0]  wbyte;
    logic [7:0]  rd_byte;

    // OR-reduce of a source vector, used for both levels
    function automatic logic any_set(input logic [12:0] v);
        any_set = |v;
    endfunction

    // register readback by byte offset
    function automatic logic [7:0] read_reg(
        input tlp_pkg::tlp_state_t st,
        input logic [7:0]          ofs
    );
        unique case (ofs)
            tlp_pkg::OFS_MAIN_CTL:   read_reg = st.main_ctl;
            tlp_pkg::OFS_EDGE_CTL:   read_reg = st.edge_ctl;
            tlp_pkg::OFS_PIN_CTL:    read_reg = st.pin_ctl;
            tlp_pkg::OFS_RESET_CTL:  read_reg = {st.prio_en, 7'h00};
            tlp_pkg::OFS_PIN_CHG_EN: read_reg = st.pin_chg_en;
            tlp_pkg::OFS_SERVICE:    read_reg = {6'h00, st.in_high,
                                                 st.in_low};
            default:                 read_reg = 8'h00;
        endcase
    endfunction

    // ========================================================
    // pin synchronisers: three external pins and the port
    tlp_pin_sync #(
        .W(11)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .pin     ({port_pin, ext_irq_pin}),
        .level   (pin_level),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // ========================================================
    // event detection
    always_comb
    begin
        // edge select: 1 rising, 0 falling
        ext_evt[0] = s.edge_ctl[tlp_pkg::EXT0_EDGE_BIT] ? pin_rise[0]
                                                       : pin_fall[0];
        ext_evt[1] = s.edge_ctl[tlp_pkg::EXT1_EDGE_BIT] ? pin_rise[1]
                                                       : pin_fall[1];
        ext_evt[2] = s.edge_ctl[tlp_pkg::EXT2_EDGE_BIT] ? pin_rise[2]
                                                       : pin_fall[2];
        // only enabled pins that changed count
        pchg_evt = |((pin_level[10:3] ^ s.port_last) & s.pin_chg_en);
    end

    // ========================================================
    // request arbitration
    always_comb
    begin
        // order: tmr0, ext0, pchg, ext1, ext2
        core_pend = {
            s.pin_ctl[tlp_pkg::EXT2_FLAG_BIT]
                & s.pin_ctl[tlp_pkg::EXT2_EN_BIT],
            s.pin_ctl[tlp_pkg::EXT1_FLAG_BIT]
                & s.pin_ctl[tlp_pkg::EXT1_EN_BIT],
            s.main_ctl[tlp_pkg::PCHG_FLAG_BIT]
                & s.main_ctl[tlp_pkg::PCHG_EN_BIT],
            s.main_ctl[tlp_pkg::EXT0_FLAG_BIT]
                & s.main_ctl[tlp_pkg::EXT0_EN_BIT],
            s.main_ctl[tlp_pkg::TMR0_FLAG_BIT]
                & s.main_ctl[tlp_pkg::TMR0_EN_BIT]};
        core_prio = {
            s.pin_ctl[tlp_pkg::EXT2_PRIO_BIT],
            s.pin_ctl[tlp_pkg::EXT1_PRIO_BIT],
            s.edge_ctl[tlp_pkg::PCHG_PRIO_BIT],
            1'b1,                                  // ext0 fixed high
            s.edge_ctl[tlp_pkg::TMR0_PRIO_BIT]};
        high_any = any_set({periph_req & periph_prio,
                            core_pend & core_prio});
        low_any  = any_set({periph_req & ~periph_prio,
                            core_pend & ~core_prio});
        if (s.prio_en)
        begin
            take_high = s.main_ctl[tlp_pkg::GLOBAL_HIGH_EN_BIT]
                        & high_any;
            take_low  = s.main_ctl[tlp_pkg::GLOBAL_HIGH_EN_BIT]
                        & s.main_ctl[tlp_pkg::PERIPH_LOW_EN_BIT]
                        & low_any & ~take_high;
        end
        else
        begin
            // compatibility: priority bits ignored
            take_high = s.main_ctl[tlp_pkg::GLOBAL_HIGH_EN_BIT]
                        & (|core_pend
                           | (s.main_ctl[tlp_pkg::PERIPH_LOW_EN_BIT]
                              & |periph_req));
            take_low  = 1'b0;
        end
        // taken at the next boundary, return has precedence
        take_any = core_in.instr_end & ~core_in.return_from_isr_instr
                   & (take_high | take_low);
    end

    // ========================================================
    // bus decode
    always_comb
    begin
        bus_start = hsel & htrans[1] & hready;
        do_write  = (s.bus == tlp_pkg::BUS_WAIT) & s.bus_wr;
        wbyte     = hwdata[7:0];
        rd_byte   = read_reg(s, s.bus_addr);
    end

    // ========================================================
    // next state
    always_comb
    begin
        next_s           = s;
        next_s.hresp     = 1'b0;
        next_s.core.vec_valid = 1'b0;
        next_s.core.push = 1'b0;
        next_s.port_last = pin_level[10:3];

        // bus slave: one wait cycle per transfer
        unique case (s.bus)
            tlp_pkg::BUS_IDLE:
            begin
                if (bus_start)
                begin
                    next_s.bus       = tlp_pkg::BUS_WAIT;
                    next_s.bus_wr    = hwrite;
                    next_s.bus_addr  = {haddr[7:2], 2'b00};
                    next_s.hreadyout = 1'b0;
                end
            end
            tlp_pkg::BUS_WAIT:
            begin
                next_s.bus       = tlp_pkg::BUS_IDLE;
                next_s.hreadyout = 1'b1;
                next_s.hrdata    = s.bus_wr ? 32'h0000_0000
                                            : {24'h000000, rd_byte};
            end
        endcase

        // software writes
        if (do_write)
        begin
            unique case (s.bus_addr)
                tlp_pkg::OFS_MAIN_CTL:   next_s.main_ctl = wbyte;
                tlp_pkg::OFS_EDGE_CTL:
                    next_s.edge_ctl = wbyte & tlp_pkg::MSK_EDGE_CTL;
                tlp_pkg::OFS_PIN_CTL:
                    next_s.pin_ctl = wbyte & tlp_pkg::MSK_PIN_CTL;
                tlp_pkg::OFS_RESET_CTL:
                    next_s.prio_en = wbyte[tlp_pkg::PRIO_LEVEL_EN_BIT];
                tlp_pkg::OFS_PIN_CHG_EN: next_s.pin_chg_en = wbyte;
                default:
                begin
                end
            endcase
        end

        // hardware sets flags over any clear
        if (timer_zero_overflow)
            next_s.main_ctl[tlp_pkg::TMR0_FLAG_BIT] = 1'b1;
        if (ext_evt[0])
            next_s.main_ctl[tlp_pkg::EXT0_FLAG_BIT] = 1'b1;
        if (pchg_evt)
            next_s.main_ctl[tlp_pkg::PCHG_FLAG_BIT] = 1'b1;
        if (ext_evt[1])
            next_s.pin_ctl[tlp_pkg::EXT1_FLAG_BIT] = 1'b1;
        if (ext_evt[2])
            next_s.pin_ctl[tlp_pkg::EXT2_FLAG_BIT] = 1'b1;

        // return re-enables the level being left
        if (core_in.instr_end & core_in.return_from_isr_instr)
        begin
            if (s.prio_en & ~s.in_high & s.in_low)
            begin
                next_s.main_ctl[tlp_pkg::PERIPH_LOW_EN_BIT] = 1'b1;
                next_s.in_low = 1'b0;
            end
            else
            begin
                next_s.main_ctl[tlp_pkg::GLOBAL_HIGH_EN_BIT] = 1'b1;
                next_s.in_high = 1'b0;
                if (!s.prio_en)
                    next_s.in_low = 1'b0;
            end
        end

        // entry: push, vector, mask the level
        if (take_any)
        begin
            next_s.core.vec_valid = 1'b1;
            next_s.core.push      = 1'b1;
            next_s.core.push_addr = core_in.ret_addr;
            if (take_high)
            begin
                next_s.core.vec_addr = tlp_pkg::VEC_HIGH;
                next_s.main_ctl[tlp_pkg::GLOBAL_HIGH_EN_BIT] = 1'b0;
                next_s.in_high = 1'b1;
            end
            else
            begin
                next_s.core.vec_addr = tlp_pkg::VEC_LOW;
                next_s.main_ctl[tlp_pkg::PERIPH_LOW_EN_BIT] = 1'b0;
                next_s.in_low = 1'b1;
            end
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s            <= '0;
            s.main_ctl   <= tlp_pkg::RST_MAIN_CTL;
            s.edge_ctl   <= tlp_pkg::RST_EDGE_CTL;
            s.pin_ctl    <= tlp_pkg::RST_PIN_CTL;
            s.pin_chg_en <= tlp_pkg::RST_PIN_CHG_EN;
            s.bus        <= tlp_pkg::BUS_IDLE;
            s.hreadyout  <= 1'b1;
        end
        else if (ce)
            s <= next_s;
    end

    // outputs straight from the state register
    assign hrdata    = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp     = s.hresp;
    assign core_out  = s.core;

    // ========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_compat_vector: assert property (
        s.core.vec_valid && !$past(s.prio_en)
            |-> s.core.vec_addr == tlp_pkg::VEC_HIGH)
        else $error("compat mode vectored away from high vector");

    chk_low_gate: assert property (
        ce && take_any && !take_high
            |-> s.main_ctl[7] && s.main_ctl[6] && s.prio_en)
        else $error("low entry without both enables");

    chk_entry_clears: assert property (
        ce && take_any && take_high |=> !s.main_ctl[7] && s.in_high)
        else $error("high entry left high enable set");

    chk_push_vector: assert property (
        ce && take_any |=> s.core.push && s.core.vec_valid
            && s.core.push_addr == $past(core_in.ret_addr))
        else $error("entry without push of return address");

    chk_high_blocks: assert property (
        ce && core_in.instr_end && !s.main_ctl[7] |=> !s.core.vec_valid)
        else $error("vectored while high enable clear");

    chk_no_low_in_high: assert property (
        s.in_high && s.prio_en
            |-> !(ce && take_any && !take_high))
        else $error("low request taken during high routine");

    chk_ext1_flag: assert property (
        ce && ext_evt[1] |=> s.pin_ctl[tlp_pkg::EXT1_FLAG_BIT])
        else $error("ext pin one edge did not set flag");

    chk_return_sets: assert property (
        ce && core_in.instr_end && core_in.return_from_isr_instr && !s.prio_en
            |=> s.main_ctl[7])
        else $error("return did not re-enable interrupts");

    chk_bus_wait: assert property (
        ce && !s.hreadyout |=> s.hreadyout)
        else $error("bus wait longer than one cycle");

    cov_high_entry: cover property (
        s.core.vec_valid && s.core.vec_addr == tlp_pkg::VEC_HIGH);
    cov_low_entry: cover property (
        s.core.vec_valid && s.core.vec_addr == tlp_pkg::VEC_LOW);
    cov_preempt: cover property (
        s.in_low && s.core.vec_valid
            && s.core.vec_addr == tlp_pkg::VEC_HIGH);

endmodule // tlp_intc

// File: testbench/tlp_core_model.sv
// Purpose: behavioural core for the interrupt controller
// Assumes: one instruction boundary every four clocks
// Notes:   returns only when asked and only with a live entry
`timescale 1ns/1ps
module tlp_core_model (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   ret_req,
    input  wire tlp_pkg::tlp_core_out_t core_out,
    output tlp_pkg::tlp_core_in_t       core_in,
    output logic [15:0]                 last_vec,
    output int                          entries,
    output int                          rets
);
    logic [1:0]  phase;
    logic        pend;
    logic [15:0] pc;
    int          depth;
    // ========================================================
    // boundaries, returns and return stack depth
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase <= 2'h0;
            pend <= 1'b0;
            pc <= 16'h0100;
            core_in <= '0;
            last_vec <= 16'h0000;
            entries <= 0;
            rets <= 0;
            depth <= 0;
        end
        else
        begin
            phase <= phase + 2'h1;
            pc <= pc + 16'h0002;
            core_in.instr_end <= (phase == 2'h3);
            core_in.return_from_isr_instr <= (phase == 2'h3) && (pend || ret_req)
                              && (depth > 0);
            // resume address steady from boundary to boundary
            if (phase == 2'h3)
                core_in.ret_addr <= pc;
            if (ret_req)
                pend <= 1'b1;
            if (core_in.instr_end && core_in.return_from_isr_instr)
            begin
                pend <= 1'b0;
                rets <= rets + 1;
                depth <= depth - 1;
            end
            // vector load with return push
            if (core_out.vec_valid && core_out.push)
            begin
                depth <= depth + 1;
                last_vec <= core_out.vec_addr;
                entries <= entries + 1;
            end
        end
    end
endmodule // tlp_core_model

// File: testbench/two_level_priority_interrupt_ctrl_tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: single AHB-Lite slave, core model on the far side
// Notes:   each scenario starts from a fresh reset
`timescale 1ns/1ps
module two_level_priority_interrupt_ctrl_tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        tmr_ovf;
    logic [2:0]  ext_pin;
    logic [7:0]  port_pin;
    logic [7:0]  periph_req;
    logic [7:0]  periph_prio;
    logic        ce;
    logic        ret_req;
    logic [15:0] last_vec;
    int          entries;
    int          rets;
    int          miscompares;
    int          num_checks;
    int          cycles;
    tlp_pkg::tlp_core_in_t  core_in;
    tlp_pkg::tlp_core_out_t core_out;
    // ========================================================
    // design, core model, clock and run limit
    tlp_intc u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .timer_zero_overflow(tmr_ovf), .ext_irq_pin(ext_pin),
        .port_pin(port_pin), .periph_req(periph_req),
        .periph_prio(periph_prio), .core_in(core_in), .core_out(core_out));
    tlp_core_model u_core (.hclk(hclk), .hresetn(hresetn),
        .ret_req(ret_req), .core_out(core_out), .core_in(core_in),
        .last_vec(last_vec), .entries(entries), .rets(rets));
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            conclude();
        end
    end
    // ========================================================
    // shared tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic rst();
        hresetn <= 1'b0;
        ext_pin <= 3'h0;
        port_pin <= 8'h00;
        periph_req <= 8'h00;
        periph_prio <= 8'h00;
        ce <= 1'b1;
        idle(5);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hwdata <= ~hwdata;  // stale data lines never look valid
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    // whole-word single writes, never a memory-to-memory move
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic pulse();
        tmr_ovf <= 1'b1;
        @(posedge hclk);
        tmr_ovf <= 1'b0;
    endtask
    task automatic no_ent(input int n);
        int e0;
        e0 = entries;
        idle(n);
        chk(entries, e0);
    endtask
    task automatic wait_ent(input int lim, input logic [15:0] v);
        int e0;
        int c;
        e0 = entries;
        c = 0;
        while (entries == e0 && c < lim)
        begin
            @(posedge hclk);
            c++;
        end
        chk({31'h0, c < lim}, 32'h1);
        chk({16'h0, last_vec}, {16'h0, v});
        chk({16'h0, core_out.push_addr}, {16'h0, core_in.ret_addr});
    endtask
    task automatic do_ret();
        int r0;
        r0 = rets;
        ret_req <= 1'b1;
        @(posedge hclk);
        ret_req <= 1'b0;
        idle(12);
        chk(rets, r0 + 1);
    endtask
    // ========================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                8'h14, 8'h18};
        logic [7:0] val [7] = '{8'h00, 8'hF5, 8'hC0, 8'h00, 8'h00,
                                8'h00, 8'h00};
        rst();
        wr(8'h18, 32'hFF);
        foreach (ofs[i]) rdc(ofs[i], {24'h0, val[i]});
    endtask
    task automatic t_compat();
        rst();
        wr(8'h04, 32'hF1);
        pulse();
        no_ent(20);
        rdc(8'h00, 32'h04);
        wr(8'h00, 32'h20);
        pulse();
        no_ent(20);
        wr(8'h00, 32'hA4);
        wait_ent(40, 16'h0008);
        rdc(8'h00, 32'h24);
        wr(8'h00, 32'h20);
        do_ret();
        rdc(8'h00, 32'hA0);
        periph_req <= 8'h01;
        no_ent(20);
        wr(8'h00, 32'hE0);
        wait_ent(40, 16'h0008);
    endtask
    task automatic t_prio();
        rst();
        wr(8'h0C, 32'h80);
        wr(8'h04, 32'hF1);
        wr(8'h00, 32'h20);
        pulse();
        wr(8'h00, 32'h64);
        no_ent(20);
        wr(8'h00, 32'hE4);
        wait_ent(40, 16'h0018);
        rdc(8'h00, 32'hA4);
        wr(8'h00, 32'hB4);
        ext_pin <= 3'h1;
        wait_ent(16, 16'h0008);
        rdc(8'h00, 32'h36);
        rdc(8'h14, 32'h03);
        wr(8'h00, 32'h30);
        do_ret();
        rdc(8'h00, 32'hB0);
        do_ret();
        rdc(8'h00, 32'hF0);
        periph_req <= 8'h01;
        wait_ent(40, 16'h0018);
        periph_prio <= 8'h01;
        wait_ent(40, 16'h0008);
        rdc(8'h14, 32'h03);
    endtask
    task automatic t_both();
        rst();
        wr(8'h0C, 32'h80);
        wr(8'h04, 32'hB1);
        ext_pin <= 3'h1;
        idle(8);
        rdc(8'h00, 32'h00);
        ext_pin <= 3'h0;
        pulse();
        idle(8);
        rdc(8'h00, 32'h06);
        wr(8'h00, 32'hF6);
        wait_ent(40, 16'h0008);
    endtask
    task automatic t_pins();
        rst();
        wr(8'h04, 32'hD5);
        ext_pin <= 3'h6;
        idle(8);
        rdc(8'h08, 32'hC2);
        ext_pin <= 3'h4;
        idle(20);
        rdc(8'h08, 32'hC3);
        wr(8'h08, 32'hC0);
        rdc(8'h08, 32'hC0);
    endtask
    task automatic t_port();
        rst();
        wr(8'h00, 32'h88);
        port_pin <= 8'h08;
        no_ent(20);
        rdc(8'h00, 32'h88);
        wr(8'h10, 32'h08);
        ce <= 1'b0;
        port_pin <= 8'h00;
        no_ent(20);
        ce <= 1'b1;
        wait_ent(40, 16'h0008);
        rdc(8'h00, 32'h09);
    endtask
    // ========================================================
    // main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        tmr_ovf = 1'b0;
        ext_pin = 3'h0;
        port_pin = 8'h00;
        periph_req = 8'h00;
        ret_req = 1'b0;
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        t_reset();
        t_compat();
        t_prio();
        t_both();
        t_pins();
        t_port();
        conclude();
    end
endmodule // two_level_priority_interrupt_ctrl_tb
